// ===== ibcr_ctrl.sv
// Count enable, ready, output enable and write enable logic for two interleaved banks.
`timescale 1ns/1ps
module ibcr_ctrl (
  input  wire logic                           ref_clk,
  input  wire logic                           resetn,
  input  wire logic                           bus_invalid,
  input  wire logic                           instr_burst_request,
  input  wire logic                           data_burst_request,
  input  wire logic                           instr_burst_ack,
  input  wire logic                           data_burst_ack,
  input  wire logic                           data_burst_ack_internal,
  input  wire logic                           read_not_write,
  input  wire logic                           instr_initial_state_first,
  input  wire logic                           instr_initial_state_second,
  input  wire logic                           instr_initial_state_third,
  input  wire logic                           data_initial_state_first,
  input  wire logic                           data_initial_state_second,
  input  wire logic                           data_initial_state_third,
  input  wire logic                           precharge_first_cycle,
  input  wire logic                           precharge_second_cycle,
  input  wire logic                           even_counter_low_bit,
  output logic                                even_bank_count_enable,
  output logic                                odd_bank_count_enable,
  output logic                                instr_ready,
  output logic                                data_ready,
  output logic                                instr_even_output_enable,
  output logic                                instr_odd_output_enable,
  output logic                                data_even_output_enable,
  output logic                                data_odd_output_enable,
  output logic                                write_enable,
  output logic                                log_valid,
  output logic [ibcr_pkg::LOG_WIDTH-1:0]      log_data,
  input  wire logic                           log_ready,
  output logic                                log_accept
);

  // Short local names for the state inputs keep the equations readable.
  // The sequencer holds the first state three cycles, and the second and
  // third follow it, which is what the two-cycle second state relies on.
  wire i_st1 = instr_initial_state_first;
  wire i_st2 = instr_initial_state_second;
  wire i_st3 = instr_initial_state_third;
  wire d_st1 = data_initial_state_first;
  wire d_st2 = data_initial_state_second;
  wire d_st3 = data_initial_state_third;
  wire pre_1 = precharge_first_cycle;
  wire pre_2 = precharge_second_cycle;
  wire rd    = read_not_write;
  wire wr    = ~read_not_write;
  wire low   = even_counter_low_bit;
  wire iack  = instr_burst_ack;
  wire dacki = data_burst_ack_internal;

  // Registered copies of the late bus signals.
  logic instr_burst_request_registered;
  logic data_burst_request_registered;
  logic instr_burst_ack_delayed;
  logic data_burst_ack_delayed;
  logic bus_invalid_delayed;
  logic next_write_enable;

  // The burst requests arrive too late to decode before the edge, so they are
  // captured first and every burst continuation ready term is built from the captured copies.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      instr_burst_request_registered <= ibcr_pkg::RESET_LEVEL;
      data_burst_request_registered  <= ibcr_pkg::RESET_LEVEL;
      instr_burst_ack_delayed        <= ibcr_pkg::RESET_LEVEL;
      data_burst_ack_delayed         <= ibcr_pkg::RESET_LEVEL;
      bus_invalid_delayed            <= ibcr_pkg::RESET_LEVEL;
    end else begin
      instr_burst_request_registered <= instr_burst_request;
      data_burst_request_registered  <= data_burst_request;
      instr_burst_ack_delayed        <= instr_burst_ack;
      data_burst_ack_delayed         <= data_burst_ack;
      bus_invalid_delayed            <= bus_invalid;
    end
  end

  wire i_req_q = instr_burst_request_registered;
  wire d_req_q = data_burst_request_registered;

  // Burst counting is only allowed outside the first state and both
  // precharge cycles, so a freshly loaded address survives precharge.
  wire i_burst_ok = ~i_st1 & ~pre_1 & ~pre_2;
  wire d_burst_ok = ~d_st1 & ~pre_1 & ~pre_2;

  // Continuation ready terms need a valid bus and the delayed acknowledge.
  wire i_cont = ~bus_invalid_delayed & i_burst_ok & i_req_q
                & instr_burst_ack_delayed;
  wire d_cont = ~bus_invalid_delayed & d_burst_ok & d_req_q
                & data_burst_ack_delayed;
  wire d_wr_third = ~bus_invalid_delayed & d_st3 & d_req_q
                    & data_burst_ack_delayed;

  // Even count: first in the column state, once more while the second state
  // holds (for writes only on a registered request), and later only on a registered burst request.
  wire even_instr = (iack & i_st2)
                    | (iack & i_burst_ok & i_req_q);
  wire even_read  = (dacki & rd & d_st2)
                    | (dacki & rd & d_burst_ok & d_req_q);
  wire even_write = (dacki & wr & d_st2 & ~d_st3)
                    | (dacki & wr & d_st3 & d_req_q)
                    | (dacki & wr & d_burst_ok & d_req_q);

  // Odd count uses the same burst terms; its opening term is one state later.
  wire odd_instr = (iack & i_st3)
                   | (iack & i_burst_ok & i_req_q);
  wire odd_read  = (dacki & rd & d_st3)
                   | (dacki & rd & d_burst_ok & d_req_q);
  wire odd_write = (dacki & wr & d_st3 & d_req_q)
                   | (dacki & wr & d_burst_ok & d_req_q);

  // The counters step on the next edge; the low bit of the even counter then
  // selects the bank, whether the start word was even or odd.
  assign even_bank_count_enable = even_instr | even_read | even_write;
  assign odd_bank_count_enable  = odd_instr | odd_read | odd_write;

  // Instruction ready is always given in the third state of the initial access.
  assign instr_ready = i_st3 | i_cont;

  // Data ready adds write terms that fire one cycle early, since write data
  // is latched off the bus before it is stored.
  wire d_rdy_read  = rd & (d_st3 | d_cont);
  wire d_rdy_write = wr & ((d_st2 & ~d_st3) | d_wr_third | d_cont);
  assign data_ready = d_rdy_read | d_rdy_write;

  // The low bit of the even counter steers the bus to one bank at a time.
  assign instr_even_output_enable = low & instr_ready;
  assign instr_odd_output_enable  = ~low & instr_ready;
  assign data_even_output_enable  = low & d_rdy_read;
  assign data_odd_output_enable   = ~low & d_rdy_read;

  // Write enable is registered and may lead the write; chip selects do the
  // actual strobing, which gives this heavily loaded line extra time. It is
  // set from the first state so that it already stands in the first cycle
  // of the second state.
  assign next_write_enable = dacki & wr & ~pre_1 & (d_st1 | write_enable);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      write_enable <= ibcr_pkg::RESET_LEVEL;
    end else begin
      write_enable <= next_write_enable;
    end
  end

  // Each cycle with a ready is logged once with its bank, as a data entry when both readies coincide. The log is diagnostic only: it
  // must never stall the memory timing, so a full log drops entries and the
  // acceptance is reported on log_accept instead.
  ibcr_fifo_if log_if ();

  wire log_any = instr_ready | data_ready;
  wire [ibcr_pkg::LOG_WIDTH-1:0] log_word;
  assign log_word[ibcr_pkg::LOG_SRC_BIT]  = data_ready ? ibcr_pkg::IBCR_SRC_DATA
                                                       : ibcr_pkg::IBCR_SRC_INSTR;
  assign log_word[ibcr_pkg::LOG_BANK_BIT] = low;
  assign log_word[ibcr_pkg::LOG_WR_BIT]   = data_ready & wr;

  assign log_if.in_valid  = log_any;
  assign log_if.in_data   = log_word;
  assign log_if.out_ready = log_ready;
  assign log_accept       = log_if.in_ready;

  ibcr_fifo #(
    .WIDTH (ibcr_pkg::LOG_WIDTH),
    .DEPTH (ibcr_pkg::LOG_DEPTH)
  ) u_log (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .port    (log_if.fifo)
  );

  // Data out of the log comes from the FIFO storage flip-flops.
  assign log_valid = log_if.out_valid;
  assign log_data  = log_if.out_data;

  // Checks on the generated timing.
  a_even_leads_odd: assert property (@(posedge ref_clk) disable iff (!resetn)
    (iack & i_st2 & ~i_st3)
    |-> even_bank_count_enable & ~odd_bank_count_enable)
    else $error("Even count missing or odd count early in column state.");

  a_no_count_precharge: assert property (@(posedge ref_clk) disable iff (!resetn)
    (pre_1 | pre_2) & ~i_st2 & ~i_st3 & ~d_st2 & ~d_st3
    |-> ~even_bank_count_enable & ~odd_bank_count_enable)
    else $error("Counter advanced during precharge.");

  a_instr_ready_third: assert property (@(posedge ref_clk) disable iff (!resetn)
    i_st3 |-> instr_ready)
    else $error("Instruction ready missing in third state.");

  a_instr_resume: assert property (@(posedge ref_clk) disable iff (!resetn)
    instr_burst_request & instr_burst_ack & ~bus_invalid
    ##1 (~i_st1 & ~pre_1 & ~pre_2) |-> instr_ready)
    else $error("Instruction ready missing on burst continuation.");

  a_rdy_bus_invalid: assert property (@(posedge ref_clk) disable iff (!resetn)
    bus_invalid ##1 (~i_st3 & ~d_st2 & ~d_st3) |-> ~instr_ready & ~data_ready)
    else $error("Ready after an invalid bus cycle.");

  a_rdy_no_ack: assert property (@(posedge ref_clk) disable iff (!resetn)
    ~instr_burst_ack ##1 ~i_st3 |-> ~instr_ready)
    else $error("Instruction ready without delayed acknowledge.");

  a_oe_steering: assert property (@(posedge ref_clk) disable iff (!resetn)
    instr_ready |-> (instr_even_output_enable == low)
                    && (instr_odd_output_enable == !low))
    else $error("Instruction output enable steering wrong.");

  a_data_write_early: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr & d_st2 & ~d_st3 |-> data_ready & ~data_even_output_enable
                            & ~data_odd_output_enable)
    else $error("Early write ready missing or output enabled.");

  a_doe_read_only: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr |-> ~data_even_output_enable & ~data_odd_output_enable)
    else $error("Data output enable during a write.");

  a_we_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
    dacki & wr & d_st1 & ~d_st2 & ~pre_1 |=> write_enable)
    else $error("Write enable not set in first second-state cycle.");

  a_we_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
    write_enable & dacki & wr & ~pre_1 |=> write_enable)
    else $error("Write enable dropped during the write.");

  a_write_third_req: assert property (@(posedge ref_clk) disable iff (!resetn)
    ~data_burst_request ##1 (dacki & wr & d_st3 & ~iack)
    |-> ~even_bank_count_enable)
    else $error("Write count in third state without prior request.");

endmodule

// ===== ibcr_pkg.sv
// Package of constants and types for the interleaved bank count and ready logic.
// Functional notes
// - Even and odd counter upper bits increment on different cycles.
// - Separate count enables; even leads odd by one cycle, then both advance together.
// - An asserted count enable advances its counter on the next rising clock edge.
// - For reads the first even count is the first cycle of the second state.
// - Even start address: first count moves only the low bit, marking even bank next.
// - Odd start address: first count moves whole even counter; low bit marks odd bank.
// - Second cycle of second state counts again; later counts need registered burst request.
// - Counting is blocked during both precharge cycles after a same-type restart.
// - Write even count in third initial cycle needs burst request in previous cycle.
// - Odd count enable follows even conditions but starts one cycle later.
// - Instruction ready asserts unconditionally in the third initial instruction cycle.
// - Instruction ready on previous registered request and acknowledge, outside first state/precharge.
// - Burst continuation ready is suppressed when the bus was invalid in the previous cycle.
// - Delayed burst acknowledge qualifies the burst continuation ready term.
// - Instruction ready is combinational from registered inputs.
// - Even output enable on ready with low bit high; odd with low bit low.
// - Data ready mirrors instruction ready and asserts one cycle earlier on writes.
// - Data output enables use same steering but only on reads.
// - Write enable is registered, set from first second-state cycle through the write.
// - Chip selects strobe the write, so write enable may assert early.
// - First state holds three cycles; second and third follow; third ends initial access.
// - Every access ends with two precharge cycles, the second in the first idle cycle.
package ibcr_pkg;

  // Event log word layout: source, bank, write flag.
  localparam int unsigned LOG_WIDTH   = 3;
  localparam int unsigned LOG_DEPTH   = 8;
  localparam int unsigned LOG_SRC_BIT = 2;
  localparam int unsigned LOG_BANK_BIT = 1;
  localparam int unsigned LOG_WR_BIT  = 0;

  // Reset values of the registered stage.
  localparam logic RESET_LEVEL = 1'h0;

  // Kinds of ready event placed in the log.
  typedef enum logic {
    IBCR_SRC_INSTR,
    IBCR_SRC_DATA
  } ibcr_src_t;

endpackage

// ===== ibcr_fifo_if.sv
// Interface carrying the event log between the control logic and its FIFO.
`timescale 1ns/1ps
interface ibcr_fifo_if;
  logic                           in_valid;
  logic                           in_ready;
  logic [ibcr_pkg::LOG_WIDTH-1:0] in_data;
  logic                           out_valid;
  logic                           out_ready;
  logic [ibcr_pkg::LOG_WIDTH-1:0] out_data;

  modport fill  (output in_valid, output in_data, input in_ready);
  modport drain (input out_valid, input out_data, output out_ready);
  modport fifo  (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
endinterface

// ===== ibcr_fifo.sv
// Parameterised FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ibcr_fifo #(
  parameter int unsigned WIDTH = ibcr_pkg::LOG_WIDTH,
  parameter int unsigned DEPTH = ibcr_pkg::LOG_DEPTH
) (
  input wire logic ref_clk,
  input wire logic resetn,
  ibcr_fifo_if.fifo port
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              do_push;
  wire              do_pop;

  // Full and empty come straight from the occupancy count.
  assign port.in_ready  = (count != (AW+1)'(DEPTH));
  assign port.out_valid = (count != '0);
  assign port.out_data  = mem[rd_ptr];
  assign do_push        = port.in_valid & port.in_ready;
  assign do_pop         = port.out_valid & port.out_ready;

  // Storage is written without reset; only the pointers and the count carry control state.
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= port.in_data;
    end
  end

  // Pointers wrap at the depth, which keeps odd depths legal.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  a_fifo_no_overrun: assert property (@(posedge ref_clk) disable iff (!resetn)
    count <= (AW+1)'(DEPTH)) else $error("FIFO occupancy above depth.");
endmodule

// ===== ibcr_bus_model.sv
// Processor bus model: raw burst requests, bus invalid and a log drain that can stall.
`timescale 1ns/1ps
module ibcr_bus_model (
  input  wire logic ref_clk,
  input  wire logic stall,
  output logic      instr_burst_request,
  output logic      data_burst_request,
  output logic      bus_invalid,
  output logic      log_ready
);
  initial begin
    instr_burst_request = 1'b0;
    data_burst_request  = 1'b0;
    bus_invalid         = 1'b0;
    log_ready           = 1'b0;
  end

  // The processor changes its lines after the falling edge, so requests arrive late but settled.
  // Bus invalid is rare, which mimics another master borrowing the bus now and then.
  always @(negedge ref_clk) begin
    instr_burst_request <= ($urandom % 4) != 0;
    data_burst_request  <= ($urandom % 4) != 0;
    bus_invalid         <= ($urandom % 8) == 0;
    log_ready           <= ~stall & (($urandom % 2) == 1);
  end
endmodule

// ===== ibcr_bench.sv
// Self-checking testbench for the interleaved bank count and ready logic.
`timescale 1ns/1ps
module ibcr_bench;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0, prst = 1'b0, stall = 1'b0;
  logic ia = 1'b0, da = 1'b0, dbi = 1'b0, sel = 1'b0, rw = 1'b1, ps = 1'b0, prw = 1'b1;
  logic q1 = 1'b0, q2 = 1'b0, q3 = 1'b0, p1 = 1'b0, p2 = 1'b0, lo = 1'b0;
  logic ib_d, db_d, bv_d, ia_d, da_d, we_m, e_push;
  logic [2:0] e_word;
  logic [2:0] fq[$];
  logic [13:0] exq[$];
  int num_errors = 0, checked = 0;
  wire ibr, dbr, binv, lrdy, c0, c1, ir, dr, io0, io1, do0, do1, we, lv, la, lacc;
  wire [2:0] ld;
  wire ist1 = ~sel & q1, ist2 = ~sel & q2, ist3 = ~sel & q3;
  wire dst1 = sel & q1, dst2 = sel & q2, dst3 = sel & q3;

  ibcr_ctrl ibcr_ctrl_i (.ref_clk(ref_clk), .resetn(resetn), .bus_invalid(binv),
    .instr_burst_request(ibr), .data_burst_request(dbr), .instr_burst_ack(ia),
    .data_burst_ack(da), .data_burst_ack_internal(dbi), .read_not_write(rw),
    .instr_initial_state_first(ist1), .instr_initial_state_second(ist2),
    .instr_initial_state_third(ist3), .data_initial_state_first(dst1),
    .data_initial_state_second(dst2), .data_initial_state_third(dst3),
    .precharge_first_cycle(p1), .precharge_second_cycle(p2), .even_counter_low_bit(lo),
    .even_bank_count_enable(c0), .odd_bank_count_enable(c1), .instr_ready(ir),
    .data_ready(dr), .instr_even_output_enable(io0), .instr_odd_output_enable(io1),
    .data_even_output_enable(do0), .data_odd_output_enable(do1), .write_enable(we),
    .log_valid(lv), .log_data(ld), .log_ready(lrdy), .log_accept(lacc));
  ibcr_bus_model ibcr_bus_model_i (.ref_clk(ref_clk), .stall(stall),
    .instr_burst_request(ibr), .data_burst_request(dbr), .bus_invalid(binv),
    .log_ready(lrdy));

  always #2.5 ref_clk = ~ref_clk;

  // Reference copies of the registered terms and of the event log.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {ib_d, db_d, bv_d, ia_d, da_d, we_m} <= 6'h00;
      fq.delete();
    end else begin
      if (fq.size() != 0 && lrdy) fq.delete(0);
      if (e_push) fq.push_back(e_word);
      {ib_d, db_d, bv_d, ia_d, da_d} <= {ibr, dbr, binv, ia, da};
      we_m <= dbi & ~rw & ~p1 & (dst1 | we_m);
    end
  end

  // Works out every output for the cycle just driven and queues the note.
  task automatic note();
    logic ib, db, xc0, xc1, xir, xdr, acc;
    ib = ~ist1 & ~p1 & ~p2;
    db = ~dst1 & ~p1 & ~p2;
    xc0 = ia & (ist2 | ib & ib_d)
          | dbi & (rw & dst2 | db & db_d | ~rw & (dst2 & ~dst3 | dst3 & db_d));
    xc1 = ia & (ist3 | ib & ib_d) | dbi & (rw & dst3 | db & db_d | ~rw & dst3 & db_d);
    xir = ist3 | ~bv_d & ib & ib_d & ia_d;
    xdr = rw & dst3 | ~rw & dst2 & ~dst3 | ~bv_d & db_d & da_d & (db | ~rw & dst3);
    acc = fq.size() < 8;
    e_push = (xir | xdr) & acc;
    e_word = {xdr, lo, xdr & ~rw};
    exq.push_back({xc0, xc1, xir, xdr, lo & xir, ~lo & xir,
                   rw & lo & (dst3 | ~bv_d & db & db_d & da_d),
                   rw & ~lo & (dst3 | ~bv_d & db & db_d & da_d),
                   we_m, fq.size() != 0, acc, (fq.size() != 0) ? fq[0] : 3'h0});
  endtask

  // One bus cycle: inputs change just after the falling edge, then the note is taken.
  task automatic cyc(input logic a, input logic [2:0] q, input logic [1:0] p);
    @(negedge ref_clk);
    resetn = prst;
    sel = ps;
    rw = prw;
    ia = a & ~ps;
    da = a & ps;
    dbi = a & ps;
    {q1, q2, q3} = q;
    {p1, p2} = p;
    lo = $urandom % 2;
    #1 note();
  endtask

  task automatic chk(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk3(input string n, input logic [2:0] e, input logic [2:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Compares the oldest note once the outputs of that cycle have settled.
  always @(negedge ref_clk) begin
    logic [13:0] e;
    #2;
    if (exq.size() != 0) begin
      e = exq.pop_front();
      chk("even_count", e[13], c0);
      chk("odd_count", e[12], c1);
      chk("instr_ready", e[11], ir);
      chk("data_ready", e[10], dr);
      chk("instr_even_oe", e[9], io0);
      chk("instr_odd_oe", e[8], io1);
      chk("data_even_oe", e[7], do0);
      chk("data_odd_oe", e[6], do1);
      chk("write_enable", e[5], we);
      chk("log_valid", e[4], lv);
      chk("log_accept", e[3], lacc);
      if (e[4]) chk3("log_data", e[2:0], ld);
    end
  end

  // Initial access, a burst of n words, then the two precharge cycles.
  // With susp set the acknowledge stays up, as when a new access of the same kind follows.
  task automatic access(input logic s, input logic r, input int n, input logic susp);
    ps = s;
    prw = r;
    cyc(1'b1, 3'h4, 2'h0);
    cyc(1'b1, 3'h6, 2'h0);
    cyc(1'b1, 3'h7, 2'h0);
    repeat (n) cyc(1'b1, 3'h0, 2'h0);
    cyc(susp, 3'h0, 2'h2);
    cyc(susp, 3'h0, 2'h1);
    if (!susp) cyc(1'b0, 3'h0, 2'h0);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(154));
    repeat (3) cyc(1'b0, 3'h0, 2'h0);
    prst = 1'b1;
    for (int k = 0; k < 30; k++) begin
      access(k % 3 != 0, k % 3 != 2, $urandom % 5, k % 4 == 1);
      $display("access test %0d done", k);
    end
    // The drain stalls so the log fills, refuses, and then empties again.
    stall = 1'b1;
    repeat (6) access(1'b0, 1'b1, 3, 1'b0);
    stall = 1'b0;
    repeat (24) cyc(1'b0, 3'h0, 2'h0);
    $display("log fill and drain test done");
    prst = 1'b0;
    access(1'b1, 1'b0, 2, 1'b0);
    prst = 1'b1;
    access(1'b1, 1'b0, 3, 1'b0);
    cyc(1'b0, 3'h0, 2'h0);
    $display("reset in mid-run test done");
    final_report();
  end

  // Cuts a hang short; the whole run needs well under 1000 cycles.
  initial begin
    #50000;
    num_errors++;
    $display("[ERR] watchdog expected finish seen hang");
    final_report();
  end
endmodule
